// file: pkg/pkif_pkg.sv
// Function
// - system flag bit 0 always reads one
// - initial-position flag is one in the first scan after start only
// - data-lost flag shows retained-data loss, valid only in first scan
// - power-on flag is one in the first scan after power-up only
// - slow clock flag is low 30 s then high 30 s, repeating
// - fast clock flag is low 0.5 s then high 0.5 s, repeating
// - scan clock flag inverts once per scan cycle
// - system flags are read-only; writes do not change them
// - read-only areas take reads only; read/write areas take both
// - data area spans index 10000000 up to index 79999999 (blocks 10 to 79)
// - data address splits into block, channel, subrange and byte offset
// - 64-byte retentive user area, read/write, survives reset
// - kernel status bytes show stop, drive ready, temperature and alarm
package pkif_pkg;
	localparam int IDX_W = 27;
	// register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] RET_FIRST_IDX = 27'hD59F80;
	localparam logic [IDX_W-1:0] RET_LAST_IDX  = 27'hD59FBF;
	localparam logic [IDX_W-1:0] REQ_STOP_IDX  = 27'h18CBA80;
	localparam logic [IDX_W-1:0] REQ_DIST_IDX  = 27'h18CBA81;
	localparam logic [IDX_W-1:0] ST_STOP_IDX   = 27'h19BFCC0;
	localparam logic [IDX_W-1:0] ST_DRIVE_IDX  = 27'h19BFCC2;
	localparam logic [IDX_W-1:0] ST_ALARM_IDX  = 27'h19BFCC3;
	localparam logic [IDX_W-1:0] SYSFLAG_IDX   = 27'h989680;
	localparam logic [IDX_W-1:0] IRQ_STAT_IDX  = 27'h989681;
	localparam logic [IDX_W-1:0] IRQ_MASK_IDX  = 27'h989682;
	// symbolic address digit weights
	localparam logic [IDX_W-1:0] W_BLK = 27'hF4240;
	localparam logic [IDX_W-1:0] W_CHN = 27'h2710;
	localparam logic [IDX_W-1:0] W_SUB = 27'h3E8;
	localparam logic [IDX_W-1:0] M_CHN = 27'h64;
	localparam logic [IDX_W-1:0] M_SUB = 27'hA;
	localparam logic [6:0] BLK_MIN    = 7'h0A;
	localparam logic [6:0] BLK_MAX    = 7'h4F;
	localparam logic [6:0] BLK_SYS    = 7'h0A;
	localparam logic [6:0] BLK_RETAIN = 7'h0E;
	localparam logic [6:0] BLK_REQ    = 7'h1A;
	localparam logic [6:0] BLK_STAT   = 7'h1B;
	localparam int RET_BYTES = 64;
	// byte offsets inside blocks
	localparam logic [9:0] OFS_REQ_STOP = 10'h000;
	localparam logic [9:0] OFS_REQ_DIST = 10'h001;
	localparam logic [9:0] OFS_ST_STOP  = 10'h000;
	localparam logic [9:0] OFS_ST_DRIVE = 10'h002;
	localparam logic [9:0] OFS_ST_ALARM = 10'h003;
	localparam logic [9:0] OFS_SYSFLAG  = 10'h000;
	localparam logic [9:0] OFS_IRQ_STAT = 10'h001;
	localparam logic [9:0] OFS_IRQ_MASK = 10'h002;
	// field positions
	localparam int SF_ONE = 0;
	localparam int SF_INIT = 1;
	localparam int SF_LOST = 2;
	localparam int SF_PWR = 3;
	localparam int SF_SLOW = 4;
	localparam int SF_FAST = 5;
	localparam int SF_SCAN = 6;
	localparam int RQ_STOP = 1;
	localparam int RQ_ACK = 2;
	localparam int RQ_PROT_LO = 4;
	localparam int RQ_ACT_DTG = 1;
	localparam int RQ_CMD_DTG = 2;
	localparam int ST_STOP_BIT = 1;
	localparam int ST_DRIVE_BIT = 6;
	localparam int ST_TEMP_BIT = 6;
	localparam int ST_ALARM_BIT = 0;
	localparam logic [7:0] REQ_STOP_MASK = 8'hF6;
	localparam logic [7:0] REQ_DIST_MASK = 8'h06;
	localparam int IRQ_W = 4;
	localparam int IRQ_STOP = 0;
	localparam int IRQ_ALARM = 1;
	localparam int IRQ_TEMP = 2;
	localparam int IRQ_LOST = 3;
	localparam logic [7:0] REQ_RESET = 8'h00;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;
	// time base
	localparam int CLK_HZ = 40000000;
	localparam int FAST_HALF_MS = 500;
	localparam int SLOW_HALF_S = 30;
	localparam int HALF_SEC_CYC = FAST_HALF_MS * (CLK_HZ / 1000);
	localparam int SLOW_TICKS = SLOW_HALF_S * 1000 / FAST_HALF_MS;

	typedef struct packed {
		logic [6:0] blk;
		logic [6:0] chn;
		logic [3:0] sub;
		logic [9:0] ofs;
	} pkif_vaddr_t;

	// split an eight-digit symbolic index into its digit fields
	function automatic pkif_vaddr_t pkif_decode(input logic [IDX_W-1:0] idx);
		pkif_vaddr_t f;
		f.blk = 7'(idx / W_BLK);
		f.chn = 7'((idx / W_CHN) % M_CHN);
		f.sub = 4'((idx / W_SUB) % M_SUB);
		f.ofs = 10'(idx % W_SUB);
		return f;
	endfunction : pkif_decode
endpackage : pkif_pkg

// file: pkg/pkif_mem_if.sv
`timescale 1ns/1ps
// port between the register bank and the retentive byte store
interface pkif_mem_if #(
	parameter int AW = 6,
	parameter int DW = 8
);
	logic          rd_en;
	logic          wr_en;
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata;
	logic [DW-1:0] rdata;
	modport ctrl (output rd_en, wr_en, addr, wdata, input rdata);
	modport mem  (input rd_en, wr_en, addr, wdata, output rdata);
endinterface : pkif_mem_if

// file: rtl/pkif_ram.sv
`timescale 1ns/1ps
// retentive byte store; array has no reset so contents survive it
module pkif_ram #(
	parameter int DEPTH = 64
) (
	input wire logic pclk,
	pkif_mem_if.mem  port
);
	logic [7:0] mem_r [DEPTH];

	// write and registered read
	always_ff @(posedge pclk)
	begin
		if (port.wr_en)
			mem_r[port.addr] <= port.wdata;
		if (port.rd_en)
			port.rdata <= mem_r[port.addr];
	end
endmodule : pkif_ram

// file: rtl/pkif_flag_gen.sv
`timescale 1ns/1ps
// special system flag byte generator
module pkif_flag_gen #(
	parameter int HALF_SEC_CYCLES = pkif_pkg::HALF_SEC_CYC,
	parameter int SLOW_HALVES     = pkif_pkg::SLOW_TICKS
) (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       scan_strobe,
	input  wire logic       warm_start,
	input  wire logic       retain_lost,
	output logic [7:0]      flags
);
	logic [24:0] div_r;
	logic [6:0]  slow_cnt_r;
	logic        fast_r, slow_r, scan_r;
	logic        init_r, pwr_r, lost_r, cap_r, warm_r;
	wire         half_tick = (div_r == 25'(HALF_SEC_CYCLES - 1));
	wire         slow_wrap = (slow_cnt_r == 7'(SLOW_HALVES - 1));

	// free-running half-second time base drives both clock flags
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			div_r <= 25'h0000000;
			fast_r <= 1'b0;
			slow_cnt_r <= 7'h00;
			slow_r <= 1'b0;
		end
		else
		begin
			div_r <= half_tick ? 25'h0000000 : div_r + 25'h0000001;
			if (half_tick)
			begin
				fast_r <= ~fast_r;
				slow_cnt_r <= slow_wrap ? 7'h00 : slow_cnt_r + 7'h01;
				if (slow_wrap)
					slow_r <= ~slow_r;
			end
		end
	end

	// initial-position, power-on and scan clock flags move only at the scan strobe
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			init_r <= 1'b1;
			pwr_r <= 1'b1;
			scan_r <= 1'b0;
			warm_r <= 1'b0;
			cap_r <= 1'b1;
			lost_r <= 1'b0;
		end
		else
		begin
			cap_r <= 1'b0;
			if (cap_r)
				lost_r <= retain_lost; // backup state caught after release
			if (scan_strobe)
			begin
				init_r <= warm_r | warm_start;
				pwr_r <= 1'b0;
				scan_r <= ~scan_r;
				warm_r <= 1'b0;
			end
			else if (warm_start)
				warm_r <= 1'b1;
		end
	end

	assign flags = {1'b0, scan_r, fast_r, slow_r, pwr_r,
		lost_r & init_r, init_r, 1'b1};
endmodule : pkif_flag_gen

// file: rtl/pkif_top.sv
`timescale 1ns/1ps
// interface register bank between the machine program and the kernel
module pkif_top #(
	parameter int HALF_SEC_CYCLES = pkif_pkg::HALF_SEC_CYC,
	parameter int SLOW_HALVES     = pkif_pkg::SLOW_TICKS
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        scan_strobe,
	input  wire logic        warm_start,
	input  wire logic        retain_lost,
	input  wire logic        stop_active,
	input  wire logic        drive_ready,
	input  wire logic        temp_alarm,
	input  wire logic        kernel_alarm,
	output logic             stop_request,
	output logic             stop_ack,
	output logic [3:0]       protection_sel,
	output logic             cmd_dtg_request,
	output logic             act_dtg_request,
	output logic [7:0]       system_flags,
	output logic             irq
);
	localparam int IW = pkif_pkg::IDX_W;

	pkif_pkg::pkif_vaddr_t     va;
	pkif_mem_if #(.AW(6), .DW(8)) mem_bus ();

	logic [7:0]                req_stop_r;
	logic [7:0]                req_dist_r;
	logic [7:0]                rd_r;
	logic [7:0]                rd_nxt;
	logic [pkif_pkg::IRQ_W-1:0] istat_r;
	logic [pkif_pkg::IRQ_W-1:0] istat_nxt;
	logic [pkif_pkg::IRQ_W-1:0] imask_r;
	logic [pkif_pkg::IRQ_W-1:0] evt;
	logic                      stop_q_r;
	logic                      alarm_q_r;
	logic                      temp_q_r;
	logic                      lost_q_r;

	// bus phases; the slave never inserts wait states
	wire setup_ph = psel & ~penable;
	wire acc_ph   = psel & penable;
	wire wr_done  = acc_ph & pwrite;
	wire rd_done  = acc_ph & ~pwrite;

	// symbolic address split and range check
	wire [IW-1:0] idx     = paddr[IW+1:2];
	wire          hi_zero = (paddr[31:IW+2] == 3'h0);
	assign va = pkif_pkg::pkif_decode(idx);
	wire in_range = hi_zero
		& (va.blk >= pkif_pkg::BLK_MIN)
		& (va.blk <= pkif_pkg::BLK_MAX);
	wire base0 = in_range & (va.chn == 7'h00) & (va.sub == 4'h0);

	// region selects from the decoded fields
	wire blk_ret  = base0 & (va.blk == pkif_pkg::BLK_RETAIN);
	wire blk_req  = base0 & (va.blk == pkif_pkg::BLK_REQ);
	wire blk_st   = base0 & (va.blk == pkif_pkg::BLK_STAT);
	wire blk_sys  = base0 & (va.blk == pkif_pkg::BLK_SYS);
	wire hit_ram  = blk_ret
		& (va.ofs < 10'(pkif_pkg::RET_BYTES));
	wire hit_rqs  = blk_req & (va.ofs == pkif_pkg::OFS_REQ_STOP);
	wire hit_rqd  = blk_req & (va.ofs == pkif_pkg::OFS_REQ_DIST);
	wire hit_sst  = blk_st & (va.ofs == pkif_pkg::OFS_ST_STOP);
	wire hit_sdr  = blk_st & (va.ofs == pkif_pkg::OFS_ST_DRIVE);
	wire hit_sal  = blk_st & (va.ofs == pkif_pkg::OFS_ST_ALARM);
	wire hit_sys  = blk_sys & (va.ofs == pkif_pkg::OFS_SYSFLAG);
	wire hit_ist  = blk_sys & (va.ofs == pkif_pkg::OFS_IRQ_STAT);
	wire hit_imk  = blk_sys & (va.ofs == pkif_pkg::OFS_IRQ_MASK);

	// read-only and writable areas
	wire ro_area = hit_sst | hit_sdr | hit_sal
		| hit_sys | hit_ist;
	wire rw_area = hit_ram | hit_rqs | hit_rqd | hit_imk;
	wire mapped  = ro_area | rw_area;
	wire bad_acc = ~mapped | (pwrite & ro_area);

	// write strobes, effective only at the completing edge
	wire wr_ok   = wr_done & ~bad_acc;
	wire we_ram  = wr_ok & hit_ram;
	wire we_rqs  = wr_ok & hit_rqs;
	wire we_rqd  = wr_ok & hit_rqd;
	wire we_imk  = wr_ok & hit_imk;
	wire rd_clr  = rd_done & hit_ist;

	// kernel status bytes, unassigned bits read zero
	wire [7:0] st_stop = 8'(stop_active) << pkif_pkg::ST_STOP_BIT;
	wire [7:0] st_drv  = 8'(drive_ready) << pkif_pkg::ST_DRIVE_BIT;
	wire [7:0] st_alm  = (8'(temp_alarm) << pkif_pkg::ST_TEMP_BIT)
		| (8'(kernel_alarm) << pkif_pkg::ST_ALARM_BIT);

	// retentive store is read in the setup phase
	assign mem_bus.rd_en = setup_ph & ~pwrite & hit_ram;
	assign mem_bus.wr_en = we_ram;
	assign mem_bus.addr  = va.ofs[5:0];
	assign mem_bus.wdata = pwdata[7:0];

	pkif_ram #(
		.DEPTH(pkif_pkg::RET_BYTES)
	) u_ram (
		.pclk (pclk),
		.port (mem_bus.mem)
	);

	pkif_flag_gen #(
		.HALF_SEC_CYCLES(HALF_SEC_CYCLES),
		.SLOW_HALVES    (SLOW_HALVES)
	) u_flags (
		.pclk       (pclk),
		.presetn    (presetn),
		.scan_strobe(scan_strobe),
		.warm_start (warm_start),
		.retain_lost(retain_lost),
		.flags      (system_flags)
	);

	// read data selection for the register part
	always_comb
	begin
		rd_nxt = 8'h00;
		if (hit_rqs)
			rd_nxt = req_stop_r;
		else if (hit_rqd)
			rd_nxt = req_dist_r;
		else if (hit_sst)
			rd_nxt = st_stop;
		else if (hit_sdr)
			rd_nxt = st_drv;
		else if (hit_sal)
			rd_nxt = st_alm;
		else if (hit_sys)
			rd_nxt = system_flags;
		else if (hit_ist)
			rd_nxt = 8'(istat_r);
		else if (hit_imk)
			rd_nxt = 8'(imask_r);
	end

	// read data is captured at the setup edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rd_r <= 8'h00;
		else if (setup_ph & ~pwrite)
			rd_r <= rd_nxt;
	end

	// request bytes keep only their defined bits
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			req_stop_r <= pkif_pkg::REQ_RESET;
			req_dist_r <= pkif_pkg::REQ_RESET;
		end
		else
		begin
			if (we_rqs)
				req_stop_r <= pwdata[7:0]
					& pkif_pkg::REQ_STOP_MASK;
			if (we_rqd)
				req_dist_r <= pwdata[7:0]
					& pkif_pkg::REQ_DIST_MASK;
		end
	end

	// request fields towards the kernel
	assign stop_request    = req_stop_r[pkif_pkg::RQ_STOP];
	assign stop_ack        = req_stop_r[pkif_pkg::RQ_ACK];
	assign protection_sel  = req_stop_r[pkif_pkg::RQ_PROT_LO+:4];
	assign cmd_dtg_request = req_dist_r[pkif_pkg::RQ_CMD_DTG];
	assign act_dtg_request = req_dist_r[pkif_pkg::RQ_ACT_DTG];

	// rising edges of kernel conditions and of the loss report
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			stop_q_r <= 1'b0;
			alarm_q_r <= 1'b0;
			temp_q_r <= 1'b0;
			lost_q_r <= 1'b0;
		end
		else
		begin
			stop_q_r <= stop_active;
			alarm_q_r <= kernel_alarm;
			temp_q_r <= temp_alarm;
			lost_q_r <= system_flags[pkif_pkg::SF_LOST];
		end
	end

	// event vector
	always_comb
	begin
		evt = pkif_pkg::IRQ_RESET;
		evt[pkif_pkg::IRQ_STOP] = stop_active & ~stop_q_r;
		evt[pkif_pkg::IRQ_ALARM] = kernel_alarm & ~alarm_q_r;
		evt[pkif_pkg::IRQ_TEMP] = temp_alarm & ~temp_q_r;
		evt[pkif_pkg::IRQ_LOST] = system_flags[pkif_pkg::SF_LOST]
			& ~lost_q_r;
	end

	// sticky status: a read clears what it returned, new events win
	assign istat_nxt = (istat_r
		& ~(rd_clr ? rd_r[pkif_pkg::IRQ_W-1:0] : pkif_pkg::IRQ_RESET))
		| evt;

	// interrupt status and mask
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			istat_r <= pkif_pkg::IRQ_RESET;
			imask_r <= pkif_pkg::IRQ_RESET;
		end
		else
		begin
			istat_r <= istat_nxt;
			if (we_imk)
				imask_r <= pwdata[pkif_pkg::IRQ_W-1:0];
		end
	end

	// bus answers
	assign irq     = |(istat_r & imask_r);
	assign pready  = 1'b1;
	assign pslverr = acc_ph & bad_acc;
	assign prdata  = {24'h000000,
		(acc_ph & hit_ram) ? mem_bus.rdata : rd_r};
endmodule : pkif_top

// file: verif/pkif_top_properties.sv
`timescale 1ns/1ps
// port-level checks on the interface register bank
module pkif_top_properties #(
	parameter int HALF_SEC_CYCLES = 10,
	parameter int SLOW_HALVES     = 4
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        scan_strobe,
	input wire logic        stop_active,
	input wire logic        temp_alarm,
	input wire logic        kernel_alarm,
	input wire logic        stop_request,
	input wire logic        stop_ack,
	input wire logic [3:0]  protection_sel,
	input wire logic        cmd_dtg_request,
	input wire logic        act_dtg_request,
	input wire logic [7:0]  system_flags
);
	localparam logic [31:0] A_SYS = {3'h0, pkif_pkg::SYSFLAG_IDX, 2'h0};
	localparam logic [31:0] A_RQS = {3'h0, pkif_pkg::REQ_STOP_IDX, 2'h0};
	localparam logic [31:0] A_RQD = {3'h0, pkif_pkg::REQ_DIST_IDX, 2'h0};
	localparam logic [31:0] A_STS = {3'h0, pkif_pkg::ST_STOP_IDX, 2'h0};
	localparam logic [31:0] A_STA = {3'h0, pkif_pkg::ST_ALARM_IDX, 2'h0};
	logic [31:0] fast_cnt_r;
	logic        fast_q_r;
	logic        seen_r;
	wire         fast_chg = system_flags[5] != fast_q_r;
	wire         acc      = psel && penable;
	// cycles since the fast clock flag last moved
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			fast_q_r   <= 1'b0;
			fast_cnt_r <= 32'h0;
			seen_r     <= 1'b0;
		end
		else
		begin
			fast_q_r   <= system_flags[5];
			fast_cnt_r <= fast_chg ? 32'h1 : fast_cnt_r + 32'h1;
			seen_r     <= seen_r | fast_chg;
		end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	one_bit_a: assert property (system_flags[0])
		else $error("constant flag low");
	lost_first_a: assert property (
		system_flags[2] |-> system_flags[1])
		else $error("lost flag outside first scan");
	pwr_clear_a: assert property (scan_strobe |=> !system_flags[3])
		else $error("power flag after first scan");
	scan_flip_a: assert property (scan_strobe |=>
		system_flags[6] != $past(system_flags[6]))
		else $error("scan clock did not flip");
	scan_hold_a: assert property (!scan_strobe |=>
		$stable({system_flags[6], system_flags[3], system_flags[1]}))
		else $error("scan flags moved between strobes");
	fast_half_a: assert property (seen_r && fast_chg |->
		fast_cnt_r == HALF_SEC_CYCLES)
		else $error("fast clock half period wrong");
	fast_bound_a: assert property (
		fast_cnt_r <= HALF_SEC_CYCLES + 2)
		else $error("fast clock stuck");
	sys_ro_a: assert property (
		acc && pwrite && paddr == A_SYS |-> pslverr)
		else $error("flag write accepted");
	req_wr_a: assert property (
		acc && pwrite && paddr == A_RQS |=>
		{protection_sel, stop_ack, stop_request}
		== {$past(pwdata[7:4]), $past(pwdata[2:1])})
		else $error("stop request outputs wrong");
	dist_wr_a: assert property (
		acc && pwrite && paddr == A_RQD |=>
		{cmd_dtg_request, act_dtg_request} == $past(pwdata[2:1]))
		else $error("distance request outputs wrong");
	stop_rd_a: assert property (
		acc && !pwrite && paddr == A_STS |->
		prdata == {30'h0, $past(stop_active), 1'b0})
		else $error("stop status read wrong");
	alarm_rd_a: assert property (
		acc && !pwrite && paddr == A_STA |-> prdata
		== {25'h0, $past(temp_alarm), 5'h0, $past(kernel_alarm)})
		else $error("alarm status read wrong");
	rd_width_a: assert property (
		acc |-> pready && prdata[31:8] == 24'h0)
		else $error("access answer wrong");
	cover property (scan_strobe);
	cover property (acc && pslverr);
	cover property (seen_r && fast_chg);
endmodule : pkif_top_properties

bind pkif_top pkif_top_properties #(
	.HALF_SEC_CYCLES(HALF_SEC_CYCLES),
	.SLOW_HALVES(SLOW_HALVES)
) chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .scan_strobe, .stop_active, .temp_alarm,
	.kernel_alarm, .stop_request, .stop_ack, .protection_sel,
	.cmd_dtg_request, .act_dtg_request, .system_flags);

// file: verif/pkif_kernel_model.sv
`timescale 1ns/1ps
// motion kernel stand-in that answers the request byte with status levels
module pkif_kernel_model (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic stop_request,
	input  wire logic stop_ack,
	input  wire logic inj_temp,
	input  wire logic inj_alarm,
	output logic      stop_active,
	output logic      drive_ready,
	output logic      temp_alarm,
	output logic      kernel_alarm
);
	// stop latches on request; drives drop out while stopped
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			stop_active  <= 1'b0;
			drive_ready  <= 1'b0;
			temp_alarm   <= 1'b0;
			kernel_alarm <= 1'b0;
		end
		else
		begin
			stop_active  <= stop_request | (stop_active & ~stop_ack);
			drive_ready  <= ~stop_active;
			temp_alarm   <= inj_temp;
			kernel_alarm <= inj_alarm;
		end
endmodule : pkif_kernel_model

// file: verif/tb.sv
`timescale 1ns/1ps
module tb;
	localparam int HALF  = 10;
	localparam int SLOWN = 4;
	logic        pclk = 1'b0;
	logic        presetn, psel, penable, pwrite;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic        pready, pslverr, er, irq;
	logic        scan_strobe, warm_start, retain_lost, inj_temp, inj_alarm;
	logic        stop_active, drive_ready, temp_alarm, kernel_alarm;
	logic        stop_request, stop_ack, cmd_dtg_request, act_dtg_request;
	logic [3:0]  protection_sel;
	logic [7:0]  system_flags;
	logic [26:0] bad [5];
	int          n_mismatch, tests_run, i;
	pkif_top #(.HALF_SEC_CYCLES(HALF), .SLOW_HALVES(SLOWN)) dut_u (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .scan_strobe, .warm_start, .retain_lost,
		.stop_active, .drive_ready, .temp_alarm, .kernel_alarm, .stop_request,
		.stop_ack, .protection_sel, .cmd_dtg_request, .act_dtg_request,
		.system_flags, .irq);
	pkif_kernel_model kernel_u (.pclk, .presetn, .stop_request, .stop_ack,
		.inj_temp, .inj_alarm, .stop_active, .drive_ready, .temp_alarm,
		.kernel_alarm);
	// free-running bus clock
	always #12.5 pclk = ~pclk;
	task final_report;
		$display("mismatches %0d of %0d checks", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : final_report
	task check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : check
	// one apb transfer; answer taken at the edge that sees pready
	task apb(input logic wr, input logic [26:0] idx, input logic [31:0] wd);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {3'h0, idx, 2'h0};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k == 20)
		begin
			n_mismatch++;
			final_report();
		end
	endtask : apb
	task wr(input logic [26:0] idx, input logic [31:0] wd, input logic e);
		apb(1'b1, idx, wd);
		check(er, e);
	endtask : wr
	task rdc(input logic [26:0] idx, input logic [31:0] exp, input logic e);
		apb(1'b0, idx, 32'h0);
		check(rd, exp);
		check(er, e);
	endtask : rdc
	// one scan boundary, flags looked at once settled
	task strobe;
		@(posedge pclk);
		scan_strobe <= 1'b1;
		@(posedge pclk);
		scan_strobe <= 1'b0;
		@(negedge pclk);
	endtask : strobe
	// cycles between two moves of one flag bit
	task period(input int b, input int exp);
		int n, j;
		logic v;
		for (j = 0; j < 2; j++)
		begin
			@(negedge pclk);
			v = system_flags[b];
			n = 1;
			while (system_flags[b] === v && n < 200)
			begin
				@(negedge pclk);
				n++;
			end
		end
		check(n, exp);
		if (n >= 200)
			final_report();
	endtask : period
	initial
	begin
		{presetn, psel, penable, pwrite, scan_strobe, warm_start} = 6'h0;
		{paddr, pwdata} = 64'h0;
		{retain_lost, inj_temp, inj_alarm} = 3'h4;
		{n_mismatch, tests_run} = 0;
		bad = '{pkif_pkg::RET_LAST_IDX + 27'h1, pkif_pkg::RET_FIRST_IDX +
			pkif_pkg::W_CHN, pkif_pkg::ST_STOP_IDX + 27'h1, 27'h4C4B3FF,
			pkif_pkg::SYSFLAG_IDX - 27'h1};
		repeat (6) @(posedge pclk);
		check(system_flags, 8'h0B);
		presetn <= 1'b1;
		repeat (2) @(negedge pclk);
		check(system_flags & 8'h0F, 8'h0F);
		rdc(pkif_pkg::SYSFLAG_IDX, 32'h0F, 1'b0);
		wr(pkif_pkg::SYSFLAG_IDX, 32'h0, 1'b1);
		@(negedge pclk) check(system_flags[3:0], 4'hF);
		check(irq, 1'b0);
		rdc(pkif_pkg::IRQ_STAT_IDX, 32'h08, 1'b0);
		rdc(pkif_pkg::IRQ_STAT_IDX, 32'h00, 1'b0);
		strobe();
		check(system_flags & 8'h4F, 8'h41);
		strobe();
		check(system_flags & 8'h4F, 8'h01);
		@(posedge pclk) warm_start <= 1'b1;
		@(posedge pclk) warm_start <= 1'b0;
		strobe();
		check(system_flags & 8'h4F, 8'h47);
		strobe();
		check(system_flags & 8'h4F, 8'h01);
		period(5, HALF);
		period(4, HALF * SLOWN);
		rdc(pkif_pkg::IRQ_STAT_IDX, 32'h08, 1'b0);
		rdc(pkif_pkg::ST_DRIVE_IDX, 32'h40, 1'b0);
		wr(pkif_pkg::IRQ_MASK_IDX, 32'h0F, 1'b0);
		wr(pkif_pkg::REQ_STOP_IDX, 32'hFF, 1'b0);
		@(negedge pclk);
		check({protection_sel, stop_ack, stop_request}, 32'h3F);
		rdc(pkif_pkg::REQ_STOP_IDX, 32'hF6, 1'b0);
		rdc(pkif_pkg::ST_STOP_IDX, 32'h02, 1'b0);
		check(irq, 1'b1);
		rdc(pkif_pkg::IRQ_STAT_IDX, 32'h01, 1'b0);
		@(negedge pclk) check(irq, 1'b0);
		wr(pkif_pkg::ST_STOP_IDX, 32'h0, 1'b1);
		wr(pkif_pkg::REQ_DIST_IDX, 32'hFF, 1'b0);
		@(negedge pclk);
		check({cmd_dtg_request, act_dtg_request}, 32'h3);
		rdc(pkif_pkg::REQ_DIST_IDX, 32'h06, 1'b0);
		@(posedge pclk) {inj_temp, inj_alarm} <= 2'h3;
		rdc(pkif_pkg::ST_ALARM_IDX, 32'h41, 1'b0);
		rdc(pkif_pkg::IRQ_STAT_IDX, 32'h06, 1'b0);
		for (i = 0; i < 5; i++)
		begin
			rdc(bad[i], 32'h0, 1'b1);
			wr(bad[i], 32'hFF, 1'b1);
		end
		wr(pkif_pkg::RET_FIRST_IDX, 32'hA5, 1'b0);
		wr(pkif_pkg::RET_LAST_IDX, 32'h5A, 1'b0);
		@(posedge pclk) {presetn, retain_lost} <= 2'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rdc(pkif_pkg::RET_FIRST_IDX, 32'hA5, 1'b0);
		rdc(pkif_pkg::RET_LAST_IDX, 32'h5A, 1'b0);
		check(system_flags & 8'h0F, 8'h0B);
		final_report();
	end
endmodule : tb
